// >>> dv/mgmt_station_model.sv
// station management model that issues register reads and writes
`timescale 1ns/1ps

// ==========================================================================
// management station
module mgmt_station_model
  import tenbase_ops_pkg::*;
(
  // clock
  input  wire logic                  i_clk,
  // register port
  input  wire logic [15:0]           i_rdata,
  output tenbase_ops_pkg::mgmt_req_s o_mgmt
);
  // reserved fields, always written at their defaults
  localparam logic [15:0] RSVD_MASK = 16'h3fd0;
  localparam logic [15:0] RSVD_DEF  = 16'h0010;

  initial o_mgmt = '0;

  // one-cycle write pulse
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_mgmt <= '{1'b0, 1'b1, a, (d & ~RSVD_MASK) | RSVD_DEF};
    @(posedge i_clk);
    o_mgmt <= '0;
  endtask : wr

  // one-cycle read pulse; data taken just after the answering edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_mgmt <= '{1'b1, 1'b0, a, 16'h0000};
    @(posedge i_clk);
    o_mgmt <= '0;
    #1 d = i_rdata;
  endtask : rd
endmodule : mgmt_station_model

// >>> dv/tenbase_t_operations_register_bench.sv
// self-checking bench for the 10base-t operations register
`timescale 1ns/1ps

// ==========================================================================
// bench top
module tenbase_t_operations_register_bench;
  import tenbase_ops_pkg::*;
  // short limits keep the run brief
  localparam int JAB  = 50;
  localparam int LOSS = 80;
  logic        i_clk, i_reset, i_ten_mode, i_full_duplex, i_repeater;
  logic        i_rx_active, i_rx_valid_data, i_rx_idle, i_rx_link_pulse;
  logic        i_rx_pol_reversed, i_tx_en;
  logic        o_auto_pol_en, o_tx_jabber_check_en, o_sqe_collision;
  logic        o_link_pass, o_crs;
  logic [15:0] o_reg_rdata;
  logic [15:0] rv;
  mgmt_req_s   mgmt;
  int          mismatches, comparisons, gap, width;

  tenbase_t_operations_register #(.RX_JABBER_LIMIT(JAB),
    .LINK_LOSS_LIMIT(LOSS)) tenbase_t_operations_register_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_mgmt(mgmt),
    .o_reg_rdata(o_reg_rdata), .i_ten_mode(i_ten_mode),
    .i_full_duplex(i_full_duplex), .i_repeater(i_repeater),
    .i_rx_active(i_rx_active), .i_rx_valid_data(i_rx_valid_data),
    .i_rx_idle(i_rx_idle), .i_rx_link_pulse(i_rx_link_pulse),
    .i_rx_pol_reversed(i_rx_pol_reversed), .i_tx_en(i_tx_en),
    .o_auto_pol_en(o_auto_pol_en),
    .o_tx_jabber_check_en(o_tx_jabber_check_en),
    .o_sqe_collision(o_sqe_collision), .o_link_pass(o_link_pass),
    .o_crs(o_crs));

  mgmt_station_model mgmt_station_model_i (
    .i_clk(i_clk), .i_rdata(o_reg_rdata), .o_mgmt(mgmt));

  // ==========================================================================
  // compare and access helpers
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    mgmt_station_model_i.rd(a, rv);
    chk16(rv, exp);
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  // transmit burst, then time the collision pulse (200 means none)
  task automatic tx_burst(input logic jab, input logic crs);
    @(posedge i_clk);
    i_tx_en <= 1'b1;
    cyc(4);
    chk1(o_tx_jabber_check_en, jab);
    chk1(o_crs, crs);
    @(posedge i_clk);
    i_tx_en <= 1'b0;
    gap = 0;
    width = 0;
    while (o_sqe_collision !== 1'b1 && gap < 200) begin
      cyc(1);
      gap++;
    end
    while (o_sqe_collision === 1'b1 && width < 200) begin
      cyc(1);
      width++;
    end
  endtask : tx_burst

  task automatic summarize;
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // ==========================================================================
  // clock and watchdog; the tests need well under 5000 cycles
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    summarize();
  end

  // ==========================================================================
  // test sequence
  initial begin
    {i_full_duplex, i_repeater, i_rx_active, i_rx_valid_data} = '0;
    {i_rx_idle, i_rx_link_pulse, i_rx_pol_reversed, i_tx_en} = '0;
    i_ten_mode = 1'b1;
    i_reset = 1'b1;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    cyc(1);
    rd_chk(OPS_REG_ADDR, OPS_RESET_VAL);
    rd_chk(5'h13, 16'h0000);
    // every control bit set, reserved bits stay at defaults
    mgmt_station_model_i.wr(OPS_REG_ADDR, 16'hffef);
    rd_chk(OPS_REG_ADDR, 16'h003f);
    chk1(o_auto_pol_en, 1'b0);
    chk1(o_link_pass, 1'b1);
    @(posedge i_clk);
    i_ten_mode <= 1'b0;
    cyc(2);
    chk1(o_auto_pol_en, 1'b0);
    @(posedge i_clk);
    i_ten_mode <= 1'b1;
    tx_burst(1'b0, 1'b1);
    chk16(16'(gap), 16'd200);
    mgmt_station_model_i.wr(OPS_REG_ADDR, 16'h0000);
    tx_burst(1'b1, 1'b1);
    chk1(gap >= SQE_DELAY_CYC && gap <= SQE_DELAY_CYC + 5, 1'b1);
    chk16(16'(width), 16'(SQE_WIDTH_CYC));
    @(posedge i_clk);
    i_full_duplex <= 1'b1;
    tx_burst(1'b1, 1'b1);
    chk16(16'(gap), 16'd200);
    @(posedge i_clk);
    {i_full_duplex, i_repeater} <= 2'b01;
    tx_burst(1'b1, 1'b0);
    chk16(16'(gap), 16'd200);
    // suppression must not show up in the inhibit bit
    rd_chk(OPS_REG_ADDR, 16'h0010);
    @(posedge i_clk);
    i_repeater <= 1'b0;
    i_rx_pol_reversed <= 1'b1;
    cyc(2);
    rd_chk(OPS_REG_ADDR, 16'h4010);
    rd_chk(OPS_REG_ADDR, 16'h4010);
    @(posedge i_clk);
    i_rx_pol_reversed <= 1'b0;
    cyc(2);
    rd_chk(OPS_REG_ADDR, 16'h4010);
    rd_chk(OPS_REG_ADDR, 16'h0010);
    @(posedge i_clk);
    i_rx_active <= 1'b1;
    cyc(JAB + 2);
    chk1(o_crs, 1'b1);
    @(posedge i_clk);
    i_rx_active <= 1'b0;
    rd_chk(OPS_REG_ADDR, 16'h8010);
    rd_chk(OPS_REG_ADDR, 16'h0010);
    // link training with the receive pair reversed throughout
    @(posedge i_clk);
    i_rx_pol_reversed <= 1'b1;
    cyc(LOSS + 5);
    chk1(o_link_pass, 1'b0);
    @(posedge i_clk);
    i_rx_valid_data <= 1'b1;
    @(posedge i_clk);
    i_rx_valid_data <= 1'b0;
    cyc(2);
    chk1(o_link_pass, 1'b0);
    @(posedge i_clk);
    i_rx_idle <= 1'b1;
    @(posedge i_clk);
    i_rx_idle <= 1'b0;
    cyc(2);
    chk1(o_link_pass, 1'b1);
    // link pulses inside the loss time keep the link up
    repeat (3) begin
      cyc(LOSS - 20);
      @(posedge i_clk);
      i_rx_link_pulse <= 1'b1;
      @(posedge i_clk);
      i_rx_link_pulse <= 1'b0;
    end
    cyc(1);
    chk1(o_link_pass, 1'b1);
    cyc(LOSS + 5);
    chk1(o_link_pass, 1'b0);
    mgmt_station_model_i.wr(OPS_REG_ADDR, 16'h0001);
    @(posedge i_clk);
    i_rx_valid_data <= 1'b1;
    @(posedge i_clk);
    i_rx_valid_data <= 1'b0;
    cyc(2);
    chk1(o_link_pass, 1'b1);
    @(posedge i_clk);
    i_ten_mode <= 1'b0;
    cyc(2);
    chk1(o_link_pass, 1'b0);
    summarize();
  end
endmodule : tenbase_t_operations_register_bench

// >>> pkg/tenbase_ops_pkg.sv
// shared constants and types for the 10base-t operations register
package tenbase_ops_pkg;

  // ==========================================================================
  // register map and reset values
  localparam logic [4:0]  OPS_REG_ADDR   = 5'h12;
  localparam logic [15:0] OPS_RESET_VAL  = 16'h0010;
  localparam logic [15:0] RDATA_IDLE     = 16'h0000;
  localparam logic [7:0]  RSVD_HI_RESET  = 8'h00;
  localparam logic        RSVD_4_RESET   = 1'b1;

  // ==========================================================================
  // timing (clock 100 MHz)
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SQE_DELAY_NS   = 600;   // least gap after transmit end
  localparam int SQE_WIDTH_NS   = 1000;  // least collision pulse width
  localparam int RX_JABBER_MS   = 20;    // receive activity limit
  localparam int LINK_LOSS_MS   = 50;    // silence before link fails
  localparam int NS_PER_MS      = 1000000;

  // least times round up to whole cycles, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  localparam int SQE_DELAY_CYC  = ns_to_cycles(SQE_DELAY_NS);
  localparam int SQE_WIDTH_CYC  = ns_to_cycles(SQE_WIDTH_NS);
  localparam int RX_JABBER_CYC  = RX_JABBER_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int LINK_LOSS_CYC  = LINK_LOSS_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int LONG_CNT_W     = 24;
  localparam int SQE_CNT_W      = 8;

  // ==========================================================================
  // register layout, bit 15 first
  typedef struct packed {
    logic       remote_jabber;   // 15, latching high
    logic       pol_reversed;    // 14, latching high
    logic [7:0] rsvd_hi;         // 13:6
    logic       jabber_inh;      // 5
    logic       rsvd_4;          // 4
    logic       auto_pol_inh;    // 3
    logic       sqe_inh;         // 2
    logic       link_loss_inh;   // 1
    logic       squelch_inh;     // 0
  } ops_reg_s;

  // management access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_s;

  typedef enum logic [1:0] {
    LINK_FAIL = 2'b00,
    LINK_DATA = 2'b01,
    LINK_PASS = 2'b10
  } link_state_e;

  typedef enum logic [1:0] {
    SQE_IDLE  = 2'b00,
    SQE_WAIT  = 2'b01,
    SQE_PULSE = 2'b10
  } sqe_state_e;

endpackage : tenbase_ops_pkg

// >>> verilog/tenbase_t_operations_register.sv
// 10base-t operations register with its jabber, polarity, sqe and link logic
`timescale 1ns/1ps

//
// Contract
// (R1) remote jabber flag latches, clears on read
// (R2) jabber criteria applied on receive; flag only
// (R3) reversed receive polarity latches bit 14
// (R4) reversal never disturbs normal operation
// (R5) manager writes reserved bits at defaults
// (R6) bit 5 disables transmit jabber check
// (R7) bit 3 inhibits automatic polarity correction
// (R8) polarity inhibit also governs 100base-tx
// (R9) bit 2 disables sqe test generation
// (R10) sqe pulses collision after transmit ends
// (R11) sqe suppressed in full duplex, repeater
// (R12) sqe inhibit bit reads back written value
// (R13) bit 1 forces link passed state
// (R14) bit 1 clear: link from receive signalling
// (R15) bit 0 set: data alone passes link
// (R16) bit 0 clear: data then idle needed
// (R17) functions act in 10base-t mode only
// (R18) repeater: sqe off, crs receive only
// (R19) event in clearing read keeps flag set
module tenbase_t_operations_register #(
  parameter int RX_JABBER_LIMIT = tenbase_ops_pkg::RX_JABBER_CYC,
  parameter int LINK_LOSS_LIMIT = tenbase_ops_pkg::LINK_LOSS_CYC
) (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  // management register port
  input  wire tenbase_ops_pkg::mgmt_req_s i_mgmt,
  output logic [15:0]                     o_reg_rdata,
  // operating mode
  input  wire logic                       i_ten_mode,
  input  wire logic                       i_full_duplex,
  input  wire logic                       i_repeater,
  // receive path status
  input  wire logic                       i_rx_active,
  input  wire logic                       i_rx_valid_data,
  input  wire logic                       i_rx_idle,
  input  wire logic                       i_rx_link_pulse,
  input  wire logic                       i_rx_pol_reversed,
  // transmit path
  input  wire logic                       i_tx_en,
  // control outputs
  output logic                            o_auto_pol_en,
  output logic                            o_tx_jabber_check_en,
  output logic                            o_sqe_collision,
  output logic                            o_link_pass,
  output logic                            o_crs
);
  import tenbase_ops_pkg::*;

  ops_reg_s                ops;
  link_state_e             link_state;
  link_state_e             next_link;
  sqe_state_e              sqe_state;
  logic [LONG_CNT_W-1:0]   jab_cnt;
  logic [LONG_CNT_W-1:0]   loss_cnt;
  logic [SQE_CNT_W-1:0]    sqe_cnt;
  logic [SQE_CNT_W-1:0]    sqe_watch;
  logic                    tx_en_d;
  logic                    rd_hit;
  logic                    wr_hit;
  logic                    jab_event;
  logic                    pol_event;
  logic                    sqe_allowed;

  // ==========================================================================
  // access decode
  assign rd_hit = i_mgmt.rd && (i_mgmt.addr == OPS_REG_ADDR);
  assign wr_hit = i_mgmt.wr && (i_mgmt.addr == OPS_REG_ADDR);

  // ==========================================================================
  // receive jabber detection: one event when activity runs too long
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_rx_active || !i_ten_mode) begin
      jab_cnt <= '0;
    end else if (jab_cnt != LONG_CNT_W'(RX_JABBER_LIMIT)) begin
      jab_cnt <= jab_cnt + 1'b1;
    end
  end
  // counter saturates, so the event fires once per overlong activity
  assign jab_event = i_rx_active && i_ten_mode && // [R2] [R17]
                     (jab_cnt == LONG_CNT_W'(RX_JABBER_LIMIT - 1));
  assign pol_event = i_rx_pol_reversed && i_ten_mode; // [R3] [R17]

  // ==========================================================================
  // latching status flags; a new event beats the clearing read
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ops.remote_jabber <= 1'b0;
      ops.pol_reversed  <= 1'b0;
    end else begin
      if (jab_event) begin
        ops.remote_jabber <= 1'b1; // [R1] [R19]
      end else if (rd_hit) begin
        ops.remote_jabber <= 1'b0; // [R1]
      end
      if (pol_event) begin
        ops.pol_reversed <= 1'b1; // [R3] [R19]
      end else if (rd_hit) begin
        ops.pol_reversed <= 1'b0; // [R3]
      end
    end
  end

  // ==========================================================================
  // control bits; reserved bits simply hold what the manager writes
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ops.rsvd_hi       <= RSVD_HI_RESET;
      ops.jabber_inh    <= 1'b0;
      ops.rsvd_4        <= RSVD_4_RESET;
      ops.auto_pol_inh  <= 1'b0;
      ops.sqe_inh       <= 1'b0;
      ops.link_loss_inh <= 1'b0;
      ops.squelch_inh   <= 1'b0;
    end else if (wr_hit) begin
      ops.rsvd_hi       <= i_mgmt.wdata[13:6]; // [R5]
      ops.jabber_inh    <= i_mgmt.wdata[5];    // [R6]
      ops.rsvd_4        <= i_mgmt.wdata[4];    // [R5]
      ops.auto_pol_inh  <= i_mgmt.wdata[3];    // [R7]
      ops.sqe_inh       <= i_mgmt.wdata[2];    // [R9] [R12]
      ops.link_loss_inh <= i_mgmt.wdata[1];    // [R13]
      ops.squelch_inh   <= i_mgmt.wdata[0];    // [R15]
    end
  end

  // ==========================================================================
  // read data: registered, shows flags as they stood before the clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_reg_rdata <= RDATA_IDLE;
    end else if (rd_hit) begin
      o_reg_rdata <= ops; // [R12]
    end else begin
      o_reg_rdata <= RDATA_IDLE;
    end
  end

  // ==========================================================================
  // steering outputs; polarity correction spans both speeds
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_auto_pol_en        <= 1'b1;
      o_tx_jabber_check_en <= 1'b0;
      o_crs                <= 1'b0;
    end else begin
      o_auto_pol_en        <= !ops.auto_pol_inh; // [R7] [R8] [R4]
      o_tx_jabber_check_en <= i_ten_mode && !ops.jabber_inh; // [R6] [R17]
      o_crs <= i_rx_active || (i_tx_en && !i_repeater); // [R18]
    end
  end

  // ==========================================================================
  // link integrity: loss timer restarts on a receive link pulse or valid receive data
  always_ff @(posedge i_clk) begin
    if (i_reset || i_rx_link_pulse || i_rx_valid_data ||
        link_state != LINK_PASS) begin
      loss_cnt <= '0;
    end else if (loss_cnt != LONG_CNT_W'(LINK_LOSS_LIMIT)) begin
      loss_cnt <= loss_cnt + 1'b1;
    end
  end

  // next link state
  always_comb begin
    next_link = link_state;
    if (ops.link_loss_inh) begin
      next_link = LINK_PASS; // [R13]
    end else begin
      unique case (link_state)
        LINK_FAIL: begin
          if (i_rx_valid_data) begin
            // squelch inhibit skips the trailing idle
            next_link = ops.squelch_inh ? LINK_PASS : LINK_DATA; // [R15]
          end
        end
        LINK_DATA: begin
          if (ops.squelch_inh || i_rx_idle) begin
            next_link = LINK_PASS; // [R16]
          end
        end
        LINK_PASS: begin
          if (loss_cnt == LONG_CNT_W'(LINK_LOSS_LIMIT)) begin
            next_link = LINK_FAIL; // [R14]
          end
        end
        default: next_link = LINK_FAIL;
      endcase
    end
  end

  // link state register; outside 10base-t the machine rests in fail
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      link_state  <= LINK_FAIL;
      o_link_pass <= 1'b0;
    end else if (!i_ten_mode) begin
      link_state  <= LINK_FAIL; // [R17]
      o_link_pass <= 1'b0;
    end else begin
      link_state  <= next_link;
      o_link_pass <= (next_link == LINK_PASS); // [R13] [R14]
    end
  end

  // ==========================================================================
  // sqe test: delay after transmit end, then a collision pulse;
  // the inhibit bit is left untouched by automatic suppression
  assign sqe_allowed = i_ten_mode && !i_full_duplex && !i_repeater &&
                       !ops.sqe_inh; // [R9] [R11] [R18]

  always_ff @(posedge i_clk) begin
    if (i_reset || !sqe_allowed) begin
      sqe_state       <= SQE_IDLE;
      sqe_cnt         <= '0;
      o_sqe_collision <= 1'b0;
      tx_en_d         <= 1'b0;
    end else begin
      tx_en_d <= i_tx_en;
      unique case (sqe_state)
        SQE_IDLE: begin
          if (tx_en_d && !i_tx_en) begin
            sqe_state <= SQE_WAIT; // [R10]
            sqe_cnt   <= SQE_CNT_W'(SQE_DELAY_CYC - 1);
          end
        end
        SQE_WAIT: begin
          if (sqe_cnt == '0) begin
            sqe_state       <= SQE_PULSE;
            sqe_cnt         <= SQE_CNT_W'(SQE_WIDTH_CYC - 1);
            o_sqe_collision <= 1'b1; // [R10]
          end else begin
            sqe_cnt <= sqe_cnt - 1'b1;
          end
        end
        SQE_PULSE: begin
          if (sqe_cnt == '0) begin
            sqe_state       <= SQE_IDLE;
            o_sqe_collision <= 1'b0;
          end else begin
            sqe_cnt <= sqe_cnt - 1'b1;
          end
        end
        default: sqe_state <= SQE_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // assertions

  // gap watch kept apart from the sqe counter; a long repeat in a
  // property would be unrolled by the tools, a counter costs nothing
  always_ff @(posedge i_clk) begin
    if (i_reset || !sqe_allowed) begin
      sqe_watch <= '0;
    end else if (sqe_state == SQE_IDLE && tx_en_d && !i_tx_en) begin
      sqe_watch <= SQE_CNT_W'(1);
    end else if (sqe_watch == SQE_CNT_W'(SQE_DELAY_CYC)) begin
      sqe_watch <= '0;
    end else if (sqe_watch != '0) begin
      sqe_watch <= sqe_watch + 1'b1;
    end
  end
  sequence s_tx_end;
    sqe_allowed && sqe_state == SQE_IDLE && tx_en_d && !i_tx_en;
  endsequence

  sequence s_sqe_pulse;
    !o_sqe_collision [*1] ##[59:61] o_sqe_collision;
  endsequence

  a_jabber_sets: assert property (@(posedge i_clk) // [R1]
    disable iff (i_reset)
    jab_event |=> ops.remote_jabber)
    else $error("remote jabber flag not set");

  a_read_clears: assert property (@(posedge i_clk) // [R1]
    disable iff (i_reset)
    rd_hit && !jab_event && !pol_event |=>
      !ops.remote_jabber && !ops.pol_reversed)
    else $error("read did not clear latched flags");

  a_set_wins: assert property (@(posedge i_clk) disable iff (i_reset) // [R19]
    rd_hit && pol_event |=> ops.pol_reversed)
    else $error("polarity event lost on read");

  a_rdata_flags: assert property (@(posedge i_clk) // [R3]
    disable iff (i_reset)
    rd_hit |=> o_reg_rdata[15:14] == $past({ops.remote_jabber,
                                           ops.pol_reversed}))
    else $error("read data does not show latched flags");

  a_inhibit_readback: assert property (@(posedge i_clk) // [R12]
    disable iff (i_reset)
    wr_hit ##1 !wr_hit ##1 rd_hit |=>
      o_reg_rdata[2] == $past(i_mgmt.wdata[2], 3))
    else $error("sqe inhibit does not read back written value");

  a_link_forced: assert property (@(posedge i_clk) // [R13]
    disable iff (i_reset)
    ops.link_loss_inh && i_ten_mode |=> o_link_pass)
    else $error("link not forced to pass");

  a_squelch_idle: assert property (@(posedge i_clk) // [R16]
    disable iff (i_reset)
    link_state == LINK_FAIL && i_ten_mode && !ops.link_loss_inh &&
    !ops.squelch_inh && i_rx_valid_data ##1 !i_rx_idle && i_ten_mode &&
    !ops.link_loss_inh && !ops.squelch_inh |=> !o_link_pass)
    else $error("link passed without idle");

  a_sqe_pulse: assert property (@(posedge i_clk) // [R10]
    disable iff (i_reset)
    sqe_allowed && sqe_watch == SQE_CNT_W'(SQE_DELAY_CYC) |->
      ##[0:2] o_sqe_collision)
    else $error("sqe pulse missing after transmit end");

  a_sqe_gap: assert property (@(posedge i_clk) disable iff (i_reset) // [R10]
    s_tx_end |=> !o_sqe_collision [*8])
    else $error("sqe pulse came too early");

  a_sqe_suppress: assert property (@(posedge i_clk) // [R11]
    disable iff (i_reset)
    i_full_duplex || i_repeater || ops.sqe_inh |=> !o_sqe_collision)
    else $error("sqe pulse while suppressed");

  a_crs_repeater: assert property (@(posedge i_clk) // [R18]
    disable iff (i_reset)
    i_repeater && !i_rx_active |=> !o_crs)
    else $error("carrier sense on transmit in repeater mode");

endmodule : tenbase_t_operations_register
